// *** pkg/rxscp_pkg.sv ***
// Package of constants for the receiver serial control port
package rxscp_pkg;
	localparam int          NUM_LOC      = 16;
	localparam int          DATA_W       = 8;
	localparam int          ADDR_W       = 6;
	localparam int          FRAME_BITS   = 18;
	localparam int          READ_BITS    = 8;
	localparam int          DATA_LSB     = 0;
	localparam int          ADDR_LSB     = 8;
	localparam int          DIR_POS      = 14;
	localparam int          SEL_LSB      = 15;
	localparam logic [2:0]  RX_SELECT    = 3'h7;
	localparam logic        DIR_WRITE    = 1'h1;
	localparam logic [7:0]  LOC_RESET    = 8'h00;
	localparam logic [4:0]  CNT_FRAME    = 5'h12;
	typedef enum logic [1:0] {
		RXSCP_IDLE  = 2'b00,
		RXSCP_SHIFT = 2'b01,
		RXSCP_GAP   = 2'b10,
		RXSCP_OUT   = 2'b11
	} rxscp_state_t;
endpackage : rxscp_pkg

// *** hw/rxscp_port.sv ***
// Serial control port with sixteen configuration bytes
module rxscp_port (
	// Clock and resets
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        cfg_reset_i,
	// Serial link from host
	input  wire logic        frame_enable_n_i,
	input  wire logic        serial_clock_i,
	input  wire logic        serial_data_i,
	// Readback to host
	output logic             serial_readback_out_o,
	// Configuration bytes, flattened, byte 0 in low bits
	output logic [127:0]     config_o
);
	// Three-stage synchronisers for the pins
	logic [2:0] en_sync;
	logic [2:0] clk_sync;
	logic [2:0] dat_sync;
	logic       en_lvl;
	logic       clk_lvl;
	logic       dat_lvl;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_sync  <= 3'h7;
			clk_sync <= 3'h0;
			dat_sync <= 3'h0;
		end else begin
			en_sync  <= {en_sync[1:0], frame_enable_n_i};
			clk_sync <= {clk_sync[1:0], serial_clock_i};
			dat_sync <= {dat_sync[1:0], serial_data_i};
		end
	end

	// Filtered levels change once stages two and three agree
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_lvl  <= 1'h1;
			clk_lvl <= 1'h0;
			dat_lvl <= 1'h0;
		end else begin
			if (en_sync[1] == en_sync[2])
				en_lvl <= en_sync[2];
			if (clk_sync[1] == clk_sync[2])
				clk_lvl <= clk_sync[2];
			if (dat_sync[1] == dat_sync[2])
				dat_lvl <= dat_sync[2];
		end
	end

	// Edge detection on filtered levels
	logic en_prev;
	logic clk_prev;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_prev  <= 1'h1;
			clk_prev <= 1'h0;
		end else begin
			en_prev  <= en_lvl;
			clk_prev <= clk_lvl;
		end
	end
	wire sclk_rise = clk_lvl & ~clk_prev;
	wire en_fall   = ~en_lvl & en_prev;
	wire en_rise   = en_lvl & ~en_prev;

	// Frame state
	rxscp_pkg::rxscp_state_t state;
	rxscp_pkg::rxscp_state_t next_state;
	logic [17:0] shift_reg;
	logic [4:0]  bit_cnt;
	logic        gap_pulse;
	logic [3:0]  rd_addr;
	logic [7:0]  rd_byte;
	logic [3:0]  out_cnt;
	logic [7:0]  loc [rxscp_pkg::NUM_LOC];

	// A command is acted on only as the enable rises at the end of shifting
	function automatic logic cmd_end(input rxscp_pkg::rxscp_state_t st, input logic rise, input logic ok);
		cmd_end = rise && (st == rxscp_pkg::RXSCP_SHIFT) && ok;
	endfunction : cmd_end

	// Command field decode of the shifted frame
	wire [2:0] cmd_sel  = shift_reg[rxscp_pkg::SEL_LSB +: 3];
	wire       cmd_dir  = shift_reg[rxscp_pkg::DIR_POS];
	wire [5:0] cmd_addr = shift_reg[rxscp_pkg::ADDR_LSB +: rxscp_pkg::ADDR_W];
	wire [7:0] cmd_data = shift_reg[rxscp_pkg::DATA_LSB +: rxscp_pkg::DATA_W];
	wire       cnt_ok   = (bit_cnt == rxscp_pkg::CNT_FRAME);
	wire       sel_ok   = (cmd_sel == rxscp_pkg::RX_SELECT);
	wire       addr_ok  = (cmd_addr[5:4] == 2'h0);
	wire       frame_ok = cnt_ok && sel_ok && addr_ok;
	wire       dir_wr   = (cmd_dir == rxscp_pkg::DIR_WRITE);
	wire       do_write = cmd_end(state, en_rise, frame_ok) && dir_wr;
	wire       do_read  = cmd_end(state, en_rise, frame_ok) && !dir_wr;

	// Phase qualifiers of the sequencer
	wire in_shift    = (state == rxscp_pkg::RXSCP_SHIFT);
	wire in_gap      = (state == rxscp_pkg::RXSCP_GAP);
	wire in_out      = (state == rxscp_pkg::RXSCP_OUT);
	// Without the extra pulse, a fall in the gap opens a fresh command frame
	wire gap_abort   = in_gap && en_fall && !gap_pulse;
	wire gap_to_out  = in_gap && en_fall && gap_pulse;
	wire frame_start = (en_fall && (state == rxscp_pkg::RXSCP_IDLE)) || gap_abort;
	wire shift_bit   = in_shift && !en_lvl && sclk_rise;
	wire out_done    = (out_cnt == 4'(rxscp_pkg::READ_BITS));
	wire out_bit     = in_out && sclk_rise && !out_done;

	// Next state of the frame sequencer
	always_comb begin
		next_state = state;
		case (state)
			rxscp_pkg::RXSCP_IDLE: begin
				if (en_fall)
					next_state = rxscp_pkg::RXSCP_SHIFT;
			end
			rxscp_pkg::RXSCP_SHIFT: begin
				if (do_read)
					next_state = rxscp_pkg::RXSCP_GAP;
				else if (en_rise)
					next_state = rxscp_pkg::RXSCP_IDLE;
			end
			rxscp_pkg::RXSCP_GAP: begin
				if (gap_to_out)
					next_state = rxscp_pkg::RXSCP_OUT;
				else if (gap_abort)
					next_state = rxscp_pkg::RXSCP_SHIFT;
			end
			rxscp_pkg::RXSCP_OUT: begin
				if (en_rise)
					next_state = rxscp_pkg::RXSCP_IDLE;
			end
			default: next_state = rxscp_pkg::RXSCP_IDLE;
		endcase
	end

	// Sequencer state register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= rxscp_pkg::RXSCP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Command shift register, LSB first, each bit entering at bit 17 and moving down
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg <= 18'h00000;
		end else if (shift_bit) begin
			shift_reg <= {dat_lvl, shift_reg[17:1]};
		end
	end

	// Bit counter saturates so a long frame never aliases to eighteen
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt <= 5'h00;
		end else if (frame_start) begin
			bit_cnt <= 5'h00;
		end else if (shift_bit && bit_cnt != 5'h1f) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// Extra pulse seen in the gap between command and readback
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_pulse <= 1'h0;
		end else if (!in_gap) begin
			gap_pulse <= 1'h0;
		end else if (sclk_rise && en_lvl) begin
			gap_pulse <= 1'h1;
		end
	end

	// Configuration store, cleared by either reset
	wire cfg_clr_n = rst_n_i & ~cfg_reset_i;
	always_ff @(posedge clock_i or negedge cfg_clr_n) begin
		if (!cfg_clr_n) begin
			for (int i = 0; i < rxscp_pkg::NUM_LOC; i++)
				loc[i] <= rxscp_pkg::LOC_RESET;
		end else if (do_write) begin
			loc[cmd_addr[3:0]] <= cmd_data;
		end
	end

	// Address of the pending read, held through the gap
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_addr <= 4'h0;
		end else if (do_read) begin
			rd_addr <= cmd_addr[3:0];
		end
	end

	// Readback byte latched as the enable falls to open the out phase
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_byte <= 8'h00;
		end else if (gap_to_out) begin
			rd_byte <= loc[rd_addr];
		end else if (out_bit) begin
			rd_byte <= {1'h0, rd_byte[7:1]};
		end
	end

	// Count of readback bits already presented
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_cnt <= 4'h0;
		end else if (gap_to_out) begin
			out_cnt <= 4'h0;
		end else if (out_bit) begin
			out_cnt <= out_cnt + 4'h1;
		end
	end

	// Readback pin, one bit per clock pulse, low outside the out phase
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_readback_out_o <= 1'h0;
		end else if (out_bit) begin
			serial_readback_out_o <= rd_byte[0];
		end else if (!in_out) begin
			serial_readback_out_o <= 1'h0;
		end
	end

	// Registered copy of the store for the analog controls
	always_ff @(posedge clock_i or negedge cfg_clr_n) begin
		if (!cfg_clr_n) begin
			config_o <= 128'h0;
		end else begin
			for (int i = 0; i < rxscp_pkg::NUM_LOC; i++)
				config_o[i*8 +: 8] <= loc[i];
		end
	end
endmodule : rxscp_port

// *** dv/rxscp_port_monitor.sv ***
// Checker for the serial control port
module rxscp_port_monitor (
	// Watched ports
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic cfg_reset_i,
	input wire logic frame_enable_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	input wire logic serial_readback_out_o,
	input wire logic [127:0] config_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Output relations
	a_reset_zero: assert property (disable iff (1'b0) !rst_n_i |-> config_o == 128'h0 && !serial_readback_out_o)
		else $error("reset");
	a_cfg_clear: assert property (cfg_reset_i |-> config_o == 128'h0) else $error("clear");
	a_cfg_release: assert property ($fell(cfg_reset_i) && frame_enable_n_i |=> $stable(config_o))
		else $error("release");
	a_idle_low: assert property (frame_enable_n_i [*8] |-> !serial_readback_out_o) else $error("idle");
	a_quiet_frame: assert property (!frame_enable_n_i [*8] |-> $stable(config_o)) else $error("frame");
	a_change_high: assert property (!$stable(config_o) && !cfg_reset_i |-> frame_enable_n_i)
		else $error("change");
	a_commit_window: assert property (frame_enable_n_i [*8] ##1 frame_enable_n_i && !cfg_reset_i |-> $stable(config_o))
		else $error("window");
	a_rb_after_pulse: assert property (!frame_enable_n_i && !$stable(serial_readback_out_o) |-> $past(serial_clock_i, 5))
		else $error("steady");
	c_rd: cover property (!frame_enable_n_i && !$stable(serial_readback_out_o));
	// Main scenarios
	c_rb: cover property ($rose(serial_readback_out_o));
	c_wr: cover property (!$stable(config_o) && !cfg_reset_i);
	c_clr: cover property (cfg_reset_i);
endmodule : rxscp_port_monitor
bind rxscp_port rxscp_port_monitor mon (.clock_i, .rst_n_i, .cfg_reset_i, .frame_enable_n_i, .serial_clock_i,
	.serial_data_i, .serial_readback_out_o, .config_o);

// *** dv/rxscp_host.sv ***
// Host model driving the serial control pins
module rxscp_host (
	// Bench clock
	input  wire logic clock_i,
	// Pins to the port
	output logic      en_n_o = 1'h1,
	output logic      sck_o  = 1'h0,
	output logic      sd_o   = 1'h0,
	input  wire logic so_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wait n rising edges of the bench clock
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick
	// Shift n bits LSB first, 400 ns link period
	task automatic shift(input logic [17:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			sd_o <= f[i];
			tick(4);
			sck_o <= 1'h1;
			tick(4);
			sck_o <= 1'h0;
		end
	endtask : shift
	// One frame, enable raised with clock low
	task automatic frame(input logic [17:0] f, input int n);
		en_n_o <= 1'h0;
		tick(4);
		shift(f, n);
		tick(4);
		en_n_o <= 1'h1;
		sd_o   <= ~sd_o;
		tick(8);
	endtask : frame
	// Read: command, extra pulse, eight readback bits
	task automatic read(input logic [5:0] a, output logic [7:0] d);
		en_n_o <= 1'h0;
		tick(4);
		shift({3'h7, 1'h0, a, 8'ha5}, 18);
		tick(4);
		en_n_o <= 1'h1;
		sd_o   <= 1'h0;
		tick(4);
		sck_o <= 1'h1;
		tick(4);
		sck_o <= 1'h0;
		tick(4);
		en_n_o <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			tick(4);
			sck_o <= 1'h1;
			tick(4);
			sck_o <= 1'h0;
			tick(3);
			d[i] = so_i;
			tick(1);
		end
		en_n_o <= 1'h1;
		sd_o   <= 1'h1;
		tick(8);
	endtask : read
endmodule : rxscp_host

// *** dv/rxscp_port_tb.sv ***
// Testbench for the serial control port
module rxscp_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i = 1'h0, rst_n_i = 1'h1, cfg_reset_i = 1'h0, en_n, sck, sd, so;
	logic [127:0] cfg, exp = 128'h0;
	int err_count = 0, checks = 0, cycles = 0;
	rxscp_host host (.clock_i(clock_i), .en_n_o(en_n), .sck_o(sck), .sd_o(sd), .so_i(so));
	rxscp_port dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_reset_i(cfg_reset_i), .frame_enable_n_i(en_n),
		.serial_clock_i(sck), .serial_data_i(sd), .serial_readback_out_o(so), .config_o(cfg));
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	// Cut a hang short
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [127:0] e, s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	// Write all locations back to back, read each back
	task automatic t_all();
		logic [7:0] d;
		for (int a = 0; a < 16; a++) host.frame({3'h7, 1'h1, 6'(a), 8'(a * 17 + 3)}, 18);
		for (int a = 0; a < 16; a++) exp[a*8 +: 8] = 8'(a * 17 + 3);
		#1000 chk("config", exp, cfg);
		for (int a = 0; a < 16; a++) begin
			host.read(6'(a), d);
			chk("readback", {120'h0, exp[a*8 +: 8]}, {120'h0, d});
		end
		$display("test all done");
	endtask : t_all
	// Refused frames and a read frame leave every location alone
	task automatic t_bad();
		host.frame({3'h6, 1'h1, 6'h01, 8'h5a}, 18);
		host.frame({3'h7, 1'h1, 6'h12, 8'h5a}, 18);
		host.frame({3'h7, 1'h1, 6'h03, 8'h5a}, 17);
		host.frame({3'h7, 1'h0, 6'h04, 8'h5a}, 18);
		#1000 chk("refused", exp, cfg);
		$display("test bad done");
	endtask : t_bad
	// Device reset clears at once, then a write lands
	task automatic t_clear();
		@(posedge clock_i) cfg_reset_i <= 1'h1;
		#1 chk("cleared", 128'h0, cfg);
		@(posedge clock_i) cfg_reset_i <= 1'h0;
		exp = {8'hc3, 120'h0};
		host.frame({3'h7, 1'h1, 6'h0f, 8'hc3}, 18);
		#1000 chk("rewrite", exp, cfg);
		$display("test clear done");
	endtask : t_clear
	initial begin
		rst_n_i <= 1'h0;
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1'h1;
		repeat (2) @(posedge clock_i);
		t_all();
		t_bad();
		t_clear();
		finish_test();
	end
endmodule : rxscp_port_tb
